/* File: hw/hd_output_format_control.sv */
// hdtv output format control: register, luma to dac a, plus chroma routing to dacs b, c
// assumes pixel ports and register strobes are driven on clk_in
`timescale 1ns/1ps
module hd_output_format_control
    import hd_fmt_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    // register access
    input  wire logic [REG_ADDR_W-1:0] reg_addr_in,
    input  wire logic [REG_DATA_W-1:0] reg_wdata_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    output logic      [REG_DATA_W-1:0] reg_rdata_out,
    // mode inputs from elsewhere in the encoder
    input  wire logic                  input_format_select_in,
    input  wire logic                  async_mode_in,
    // pixel ports
    input  wire logic [PIX_W-1:0]      y_in,
    input  wire logic [PIX_W-1:0]      cr_in,
    input  wire logic [PIX_W-1:0]      cbcr_in,
    input  wire logic                  hsync_in,
    input  wire logic                  line_start_in,
    // dac codes
    output logic      [PIX_W-1:0]      dac_a_out,
    output logic      [PIX_W-1:0]      dac_b_out,
    output logic      [PIX_W-1:0]      dac_c_out,
    output logic                       chroma_sync_out
);
    // ****************************************
    // register
    // ****************************************
    fmt_cfg_if cfg ();

    // software keeps the upper bits zero; they are neither stored nor read back
    format_register u_reg (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .reg_addr_in   (reg_addr_in),
        .reg_wdata_in  (reg_wdata_in),
        .reg_wr_in     (reg_wr_in),
        .reg_rd_in     (reg_rd_in),
        .reg_rdata_out (reg_rdata_out),
        .cfg           (cfg)
    );

    // ****************************************
    // chroma phase and sample holds
    // ****************************************
    logic             phase;      // 0 = blue sample on muxed port
    logic [PIX_W-1:0] cb_hold;
    logic [PIX_W-1:0] cr_hold;
    logic             next_phase;
    logic [PIX_W-1:0] next_cb_hold;
    logic [PIX_W-1:0] next_cr_hold;
    logic             is_422;

    assign is_422 = (input_format_select_in == FMT_422);

    // phase restarts each line so a lost sample cannot swap colours for good
    always_comb begin
        next_phase   = phase;
        next_cb_hold = cb_hold;
        next_cr_hold = cr_hold;
        if (line_start_in || !is_422) begin
            next_phase = 1'b0;
        end else begin
            next_phase = ~phase;
        end
        if (!phase) begin
            next_cb_hold = cbcr_in;
        end else begin
            next_cr_hold = cbcr_in;
        end
    end

    // registers only
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phase   <= 1'b0;
            cb_hold <= PIX_ZERO;
            cr_hold <= PIX_ZERO;
        end else begin
            phase   <= next_phase;
            cb_hold <= next_cb_hold;
            cr_hold <= next_cr_hold;
        end
    end

    // ****************************************
    // dac routing and sync insertion
    // ****************************************
    logic [PIX_W-1:0] cb_now;
    logic [PIX_W-1:0] cr_now;
    logic [PIX_W-1:0] next_dac_a;
    logic [PIX_W-1:0] next_dac_b;
    logic [PIX_W-1:0] next_dac_c;
    logic             next_sync;
    logic             sync_req;

    // in 4:2:2 the newest sample of each colour; the red port is unused
    assign cb_now = phase ? cb_hold : cbcr_in;
    assign cr_now = phase ? cbcr_in : cr_hold;

    // rgb only affects sync and async is unused, data passes through unchanged
    assign sync_req = cfg.sync_insert && !cfg.rgb_sel && hsync_in;

    always_comb begin
        next_dac_a = y_in;
        if (is_422) begin
            next_dac_b = swap_pick(cfg.dac_swap, cr_now, cb_now);
            next_dac_c = swap_pick(cfg.dac_swap, cb_now, cr_now);
        end else begin
            next_dac_b = swap_pick(cfg.dac_swap, cr_in, cbcr_in);
            next_dac_c = swap_pick(cfg.dac_swap, cbcr_in, cr_in);
        end
        next_sync = sync_req;
        if (sync_req) begin
            next_dac_b = CHROMA_SYNC;
            next_dac_c = CHROMA_SYNC;
        end
    end

    // one cycle of latency on every dac, all outputs registered
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dac_a_out       <= PIX_ZERO;
            dac_b_out       <= PIX_ZERO;
            dac_c_out       <= PIX_ZERO;
            chroma_sync_out <= 1'b0;
        end else begin
            dac_a_out       <= next_dac_a;
            dac_b_out       <= next_dac_b;
            dac_c_out       <= next_dac_c;
            chroma_sync_out <= next_sync;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_sync_req;
        cfg.sync_insert && !cfg.rgb_sel && hsync_in;
    endsequence
    sequence s_sync_out;
        chroma_sync_out && dac_b_out == CHROMA_SYNC && dac_c_out == CHROMA_SYNC;
    endsequence
    sequence s_plain_444;
        !is_422 && !sync_req;
    endsequence

    property p_rgb_pass;
        @(posedge clk_in) disable iff (rst_in)
        (cfg.rgb_sel && !async_mode_in && !is_422)
            |=> dac_a_out == $past(y_in) && !chroma_sync_out;
    endproperty
    a_rgb_pass: assert property (p_rgb_pass) else $error("rgb not passed");

    property p_rgb_async;
        @(posedge clk_in) disable iff (rst_in)
        (cfg.rgb_sel && async_mode_in && hsync_in)
            |=> dac_a_out == $past(y_in) && !chroma_sync_out;
    endproperty
    a_rgb_async: assert property (p_rgb_async) else $error("rgb lost in async");

    property p_no_sync;
        @(posedge clk_in) disable iff (rst_in)
        !cfg.sync_insert |=> !chroma_sync_out;
    endproperty
    a_no_sync: assert property (p_no_sync) else $error("unwanted chroma sync");

    property p_sync_ins;
        @(posedge clk_in) disable iff (rst_in)
        s_sync_req |=> s_sync_out;
    endproperty
    a_sync_ins: assert property (p_sync_ins) else $error("chroma sync missing");

    property p_rgb_nosync;
        @(posedge clk_in) disable iff (rst_in)
        (cfg.rgb_sel && cfg.sync_insert && hsync_in) |=> !chroma_sync_out;
    endproperty
    a_rgb_nosync: assert property (p_rgb_nosync) else $error("sync in rgb");

    property p_noswap;
        @(posedge clk_in) disable iff (rst_in)
        (s_plain_444 and !cfg.dac_swap)
            |=> dac_b_out == $past(cr_in) && dac_c_out == $past(cbcr_in);
    endproperty
    a_noswap: assert property (p_noswap) else $error("default map wrong");

    property p_swap;
        @(posedge clk_in) disable iff (rst_in)
        (s_plain_444 and cfg.dac_swap)
            |=> dac_b_out == $past(cbcr_in) && dac_c_out == $past(cr_in);
    endproperty
    a_swap: assert property (p_swap) else $error("swapped map wrong");

    // blue half of a 4:2:2 pair, then the red half that follows it
    sequence s_blue_now;
        is_422 && !sync_req && !cfg.dac_swap && !phase;
    endsequence
    sequence s_red_next;
        is_422 && !sync_req && !cfg.dac_swap && phase;
    endsequence

    property p_422_blue;
        @(posedge clk_in) disable iff (rst_in)
        s_blue_now |=> dac_c_out == $past(cbcr_in);
    endproperty
    a_422_blue: assert property (p_422_blue) else $error("4:2:2 blue wrong");

    // on the red half dac c keeps the blue sample; a line mark or sync breaks the pair
    property p_422_hold;
        @(posedge clk_in) disable iff (rst_in)
        s_blue_now ##1 s_red_next |=> dac_c_out == $past(cbcr_in, 2);
    endproperty
    a_422_hold: assert property (p_422_hold) else $error("4:2:2 blue not held");

    property p_422_red;
        @(posedge clk_in) disable iff (rst_in)
        (is_422 && !sync_req && cfg.dac_swap && phase && !line_start_in)
            |=> dac_c_out == $past(cbcr_in);
    endproperty
    a_422_red: assert property (p_422_red) else $error("4:2:2 red wrong");

    property p_444_phase;
        @(posedge clk_in) disable iff (rst_in)
        !is_422 |=> !phase;
    endproperty
    a_444_phase: assert property (p_444_phase) else $error("phase in 4:4:4");
endmodule : hd_output_format_control

/* File: hw/hd_fmt_pkg.sv */
// constants and helpers for the hd output format control block
// assumes one pixel clock domain shared by register port and pixel ports
package hd_fmt_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam int          REG_ADDR_W     = 5;
    localparam int          REG_DATA_W     = 8;
    localparam logic [4:0]  FMT_CTRL_ADDR  = 5'h05;
    localparam logic [7:0]  FMT_CTRL_RESET = 8'h00;
    localparam logic [7:0]  READ_ZERO      = 8'h00;
    localparam logic [3:0]  RSVD_READ      = 4'h0;
    // field positions in output_format_control
    localparam int          REV_BIT        = 0;
    localparam int          RGB_BIT        = 1;
    localparam int          SYNC_BIT       = 2;
    localparam int          SWAP_BIT       = 3;
    // revision code value is arbitrary
    localparam logic        REVISION_CODE  = 1'b0;

    // ****************************************
    // pixel path
    // ****************************************
    localparam int          PIX_W          = 10;
    localparam logic [9:0]  PIX_ZERO       = 10'h000;
    // chroma level driven during an inserted sync pulse, plain default
    localparam logic [9:0]  CHROMA_SYNC    = 10'h040;
    // input_format_select: 0 = 4:4:4 separate ports, 1 = 4:2:2 muxed
    localparam logic        FMT_444        = 1'b0;
    localparam logic        FMT_422        = 1'b1;

    // pick between two components by the swap bit
    function automatic logic [9:0] swap_pick(input logic       swap,
                                             input logic [9:0] plain,
                                             input logic [9:0] swapped);
        swap_pick = swap ? swapped : plain;
    endfunction : swap_pick
endpackage : hd_fmt_pkg

/* File: hw/fmt_cfg_if.sv */
// configuration bits passed from the register module to the pixel path
// assumes both ends run on the pixel clock
`timescale 1ns/1ps
interface fmt_cfg_if;
    logic rgb_sel;
    logic sync_insert;
    logic dac_swap;
    modport regs (output rgb_sel, output sync_insert, output dac_swap);
    modport path (input rgb_sel, input sync_insert, input dac_swap);
endinterface : fmt_cfg_if

/* File: hw/format_register.sv */
// output_format_control register with its read port
// assumes register strobes are synchronous to clk_in, one cycle each
`timescale 1ns/1ps
module format_register
    import hd_fmt_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    // register access
    input  wire logic [REG_ADDR_W-1:0] reg_addr_in,
    input  wire logic [REG_DATA_W-1:0] reg_wdata_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    output logic      [REG_DATA_W-1:0] reg_rdata_out,
    // configuration to the pixel path
    fmt_cfg_if.regs                    cfg
);
    // ****************************************
    // storage
    // ****************************************
    logic                  rgb_sel;
    logic                  sync_insert;
    logic                  dac_swap;
    logic                  next_rgb_sel;
    logic                  next_sync_insert;
    logic                  next_dac_swap;
    logic [REG_DATA_W-1:0] next_rdata;
    logic                  hit;

    assign hit = (reg_addr_in == FMT_CTRL_ADDR);

    // bit 0 and the upper bits are not stored, so a careless write is harmless
    always_comb begin
        next_rgb_sel     = rgb_sel;
        next_sync_insert = sync_insert;
        next_dac_swap    = dac_swap;
        next_rdata       = reg_rdata_out;
        if (reg_wr_in && hit) begin
            next_rgb_sel     = reg_wdata_in[RGB_BIT];
            next_sync_insert = reg_wdata_in[SYNC_BIT];
            next_dac_swap    = reg_wdata_in[SWAP_BIT];
        end
        if (reg_rd_in) begin
            next_rdata = hit ? {RSVD_READ, dac_swap, sync_insert, rgb_sel,
                                REVISION_CODE} : READ_ZERO;
        end
    end

    // registers only
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rgb_sel       <= FMT_CTRL_RESET[RGB_BIT];
            sync_insert   <= FMT_CTRL_RESET[SYNC_BIT];
            dac_swap      <= FMT_CTRL_RESET[SWAP_BIT];
            reg_rdata_out <= READ_ZERO;
        end else begin
            rgb_sel       <= next_rgb_sel;
            sync_insert   <= next_sync_insert;
            dac_swap      <= next_dac_swap;
            reg_rdata_out <= next_rdata;
        end
    end

    assign cfg.rgb_sel     = rgb_sel;
    assign cfg.sync_insert = sync_insert;
    assign cfg.dac_swap    = dac_swap;

    // ****************************************
    // checks
    // ****************************************
    property p_rev_read;
        @(posedge clk_in) disable iff (rst_in)
        (reg_rd_in && hit) |=> (reg_rdata_out[REV_BIT] == REVISION_CODE)
                               && (reg_rdata_out[7:4] == RSVD_READ);
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("bad rev bit");
endmodule : format_register

/* File: bench/hd_video_source.sv */
// upstream pixel source model: counting pattern with hsync and line marks
// assumes clk_in is the pixel clock and rst_in is synchronous, active high
`timescale 1ns/1ps
module hd_video_source
    import hd_fmt_pkg::*;
(
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // pixel ports toward the encoder
    output logic      [PIX_W-1:0] y_out,
    output logic      [PIX_W-1:0] cr_out,
    output logic      [PIX_W-1:0] cbcr_out,
    output logic                  hsync_out,
    output logic                  line_start_out,
    // timing-code flags for the line being sent
    output logic                  field_out,
    output logic                  vblank_out
);
    logic [PIX_W-1:0] pix;
    logic [10:0]      line_no;
    // ****************************************
    // pattern
    // ****************************************
    // each port is a different function of the count so a crossed route shows
    always @(posedge clk_in) begin
        pix <= rst_in ? 10'h000 : pix + 10'h001;
    end
    assign y_out          = pix;
    assign cr_out         = ~pix;
    assign cbcr_out       = pix ^ 10'h2AA;
    // 16-pixel lines keep the run short; sync covers the first three pixels
    assign hsync_out      = (pix[3:0] < 4'h3);
    assign line_start_out = (pix[3:0] == 4'h0);

    // line number of the 1125-line interlaced raster, advanced at each line end
    always @(posedge clk_in) begin
        if (rst_in) begin
            line_no <= 11'h001;
        end else if (pix[3:0] == 4'hF) begin
            line_no <= (line_no == 11'h465) ? 11'h001 : line_no + 11'h001;
        end
    end
    // field flag per raster half, blanking outside the two active ranges
    assign field_out  = (line_no >= 11'h233);
    assign vblank_out = !((line_no >= 11'h015 && line_no <= 11'h230)
                       || (line_no >= 11'h248 && line_no <= 11'h463));
endmodule : hd_video_source

/* File: bench/hd_output_format_control_test.sv */
// self-checking bench for the output format control block
// assumes the source model drives pixels; the bench drives register and modes
`timescale 1ns/1ps
module hd_output_format_control_test;
    import hd_fmt_pkg::*;
    logic                  clk_in = 1'b0;
    logic                  rst_in = 1'b1;
    logic [REG_ADDR_W-1:0] reg_addr_in = 5'h00;
    logic [REG_DATA_W-1:0] reg_wdata_in = 8'h00;
    logic                  reg_wr_in = 1'b0;
    logic                  reg_rd_in = 1'b0;
    logic                  fmt_in = 1'b0;
    logic                  async_in = 1'b0;
    logic [REG_DATA_W-1:0] reg_rdata_out;
    logic [PIX_W-1:0]      y, cr, cbcr, dac_a, dac_b, dac_c, eb, ec;
    logic [PIX_W-1:0]      p_y, p_cr, p_cbcr, cb_h, cr_h;
    logic                  hs, ls, csync, p_hs, p_ls, p_fmt, es, fld, vbl;
    logic                  phase = 1'b0, synced = 1'b0, ok_cb = 1'b0, ok_cr = 1'b0;
    logic                  m_rgb = 1'b0, m_sync = 1'b0, m_swap = 1'b0, active = 1'b0;
    int                    warm = 0;
    int                    num_errors = 0;
    int                    n_compared = 0;

    // ****************************************
    // clock, source and design
    // ****************************************
    always #5 clk_in = ~clk_in;
    hd_video_source SRC (.clk_in(clk_in), .rst_in(rst_in), .y_out(y), .cr_out(cr),
        .cbcr_out(cbcr), .hsync_out(hs), .line_start_out(ls), .field_out(fld),
        .vblank_out(vbl));
    hd_output_format_control DUT (.clk_in(clk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .input_format_select_in(fmt_in), .async_mode_in(async_in), .y_in(y), .cr_in(cr),
        .cbcr_in(cbcr), .hsync_in(hs), .line_start_in(ls), .dac_a_out(dac_a),
        .dac_b_out(dac_b), .dac_c_out(dac_c), .chroma_sync_out(csync));

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [PIX_W-1:0] seen, input logic [PIX_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        @(negedge clk_in);
        check({2'b00, reg_rdata_out}, {2'b00, exp});
    endtask : reg_read

    // ****************************************
    // pixel reference model
    // ****************************************
    // sampled at the falling edge so design and source updates have landed
    always @(negedge clk_in) begin
        if (p_fmt == FMT_422 && synced) begin
            if (phase) begin
                cr_h = p_cbcr;
                ok_cr = 1'b1;
            end else begin
                cb_h = p_cbcr;
                ok_cb = 1'b1;
            end
        end
        es = m_sync && !m_rgb && p_hs;
        eb = (p_fmt == FMT_444) ? (m_swap ? p_cbcr : p_cr) : (m_swap ? cb_h : cr_h);
        ec = (p_fmt == FMT_444) ? (m_swap ? p_cr : p_cbcr) : (m_swap ? cr_h : cb_h);
        if (warm > 0) begin
            warm--;
        end else if (active) begin
            check(dac_a, p_y);
            check({9'h000, csync}, {9'h000, es});
            if (es) begin
                check(dac_b, CHROMA_SYNC);
                check(dac_c, CHROMA_SYNC);
            end else if (p_fmt == FMT_444 || (ok_cb && ok_cr)) begin
                check(dac_b, eb);
                check(dac_c, ec);
            end
        end
        // the 4:2:2 phase is only trusted after a line mark seen in that mode
        phase = p_ls ? 1'b0 : ~phase;
        synced = (p_fmt == FMT_422) && (synced || p_ls);
        ok_cb = ok_cb && synced;
        ok_cr = ok_cr && synced;
        {p_y, p_cr, p_cbcr, p_hs, p_ls, p_fmt} = {y, cr, cbcr, hs, ls, fmt_in};
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        reg_read(FMT_CTRL_ADDR, {FMT_CTRL_RESET[7:1], REVISION_CODE});
        // the first line after reset lies in the blanking of the first field
        check({9'h000, fld}, 10'h000);
        check({9'h000, vbl}, 10'h001);
        reg_write(5'h03, 8'h0E);
        reg_read(5'h03, READ_ZERO);
        reg_read(FMT_CTRL_ADDR, {7'h00, REVISION_CODE});
        // every mix of rgb, sync insert and swap in both chroma formats
        for (int k = 0; k < 16; k++) begin
            // mode pins move on a rising edge, as the design expects
            @(posedge clk_in);
            active = 1'b0;
            fmt_in   <= k[3];
            async_in <= k[3] ^ k[2];
            reg_write(FMT_CTRL_ADDR, {4'h0, k[2:0], 1'b1});
            reg_read(FMT_CTRL_ADDR, {RSVD_READ, k[2:0], REVISION_CODE});
            // model modes change on a rising edge, clear of the falling-edge checker
            @(posedge clk_in);
            {m_swap, m_sync, m_rgb} = k[2:0];
            warm = 2;
            active = 1'b1;
            repeat (40) @(posedge clk_in);
        end
        active = 1'b0;
        // by now well inside the first field and past its blanking lines
        @(negedge clk_in);
        check({9'h000, fld}, 10'h000);
        check({9'h000, vbl}, 10'h000);
        summarize();
    end

    // a hung run still reaches the report
    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        summarize();
    end
endmodule : hd_output_format_control_test
